// ==== sar_adc_pkg.sv ====
// constants for the successive-approximation converter sequencer
// assumes an ahb-lite host and a separate analog front end
// How it works
// - ten-bit result over sixteen selectable channels
// - scan converts channels zero through the programmed last channel
// - each channel readable at ten or eight bits
// - compare mode reports only above or below
// - compare mode runs in single operation only
// - single-shot scan stops, continuous scan repeats
// - compare can be forced into running scan
// - scan may follow a single conversion automatically
// - running conversion can restart from beginning
// - optional sample-and-hold at conversion start
// - scan precharge assist to selectable high or low level
// - four speeds, slow or fast, normal/double
// - request pulse per single, compare, scan pass
// - hardware start from four timer events
// - normal conversion cycle counts 299/173/131/89
// - fast hold counts 191/101/95/53
// - result goes to channel's own register
// - scan follows scan select and type settings
// - compare outcome sets or clears channel bit
package sar_adc_pkg;
  localparam int NUM_CH = 16;
  localparam int RES_BITS = 10;
  localparam int CNT_W = 9;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_SINGLE = 8'h08;
  localparam logic [7:0] OFS_SCAN = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CMPRES = 8'h14;
  localparam logic [1:0] REG_DATA10 = 2'h1;
  localparam logic [1:0] REG_DATA8 = 2'h2;
  // control fields
  localparam int CTL_SCAN = 0;
  localparam int CTL_CONT = 1;
  localparam int CTL_CMP = 2;
  localparam int CTL_SH = 3;
  localparam int CTL_FSH = 4;
  localparam int CTL_FAST = 5;
  localparam int CTL_DBL = 6;
  localparam int CTL_ASSIST = 7;
  localparam int CTL_ALVL = 8;
  localparam int CTL_SAS = 9;
  localparam int CTL_TRG = 12;
  localparam int CTL_W = 15;
  localparam logic [14:0] CTRL_RST = 15'h0000;
  // command bits
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_RESTART = 2;
  localparam int CMD_FORCE = 3;
  // single register fields
  localparam int SGL_CH = 0;
  localparam int SGL_CMPV = 16;
  // trigger sources
  localparam logic [2:0] TRG_SW = 3'h0;
  localparam logic [2:0] TRG_IN2 = 3'h1;
  localparam logic [2:0] TRG_IN3 = 3'h2;
  localparam logic [2:0] TRG_OUT3 = 3'h3;
  localparam logic [2:0] TRG_TIN = 3'h4;
  // conversion lengths in clock cycles
  localparam int CYC_SN = 299;
  localparam int CYC_SD = 173;
  localparam int CYC_FN = 131;
  localparam int CYC_FD = 89;
  localparam int CYC_FSH_SN = 191;
  localparam int CYC_FSH_SD = 101;
  localparam int CYC_FSH_FN = 95;
  localparam int CYC_FSH_FD = 53;
  localparam int CYC_CMP_SN = 47;
  localparam int CYC_CMP_SD = 29;
  localparam int CYC_CMP_FN = 23;
  localparam int CYC_CMP_FD = 17;
  localparam int PRECHG_CYC = 4;
  typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_PRE, ST_CONV} seq_state_t;
endpackage : sar_adc_pkg

// ==== sar_adc_sequencer.sv ====
// sequencer, result store and ahb-lite register slave of the converter
// assumes an analog front end with channel mux, dac, comparator and
// hold switch, and timer events as one-cycle pulses on this clock
`timescale 1ns/1ps
module sar_adc_sequencer #(
  parameter int NUM_CH = sar_adc_pkg::NUM_CH,
  parameter int RES_BITS = sar_adc_pkg::RES_BITS
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // timer event triggers
  input wire logic evIn2,
  input wire logic evIn3,
  input wire logic evOut3,
  input wire logic timerInputSelectTrigger,
  // analog front end
  input wire logic cmpHigh,
  output logic [3:0] analogInputChannelSel,
  output logic [9:0] dacCode,
  output logic sampleHold,
  output logic precharge,
  output logic prechargeHigh,
  // completion request for interrupt or dma
  output logic convDoneReq
);
  import sar_adc_pkg::*;

  // datapath and address map are built for these sizes only
  if (NUM_CH < 2 || NUM_CH > 16 || RES_BITS != 10) begin : g_chk
    $error("sar_adc_sequencer: unsupported NUM_CH or RES_BITS");
  end

  seq_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [3:0] chan_r;
  logic [3:0] savedCh_r;
  logic scan_r;
  logic forced_r;
  logic pend_r;
  logic curCmp_r;
  logic done_r;
  logic [CTL_W-1:0] ctrl_r;
  logic [3:0] singleCh_r;
  logic [9:0] cmpVal_r;
  logic [3:0] scanLast_r;
  logic [NUM_CH-1:0] cmpRes_r;
  logic [9:0] data_r [NUM_CH];
  logic [9:0] sar_r;
  logic [9:0] dac_r;
  logic [9:0] sarNxt;
  logic [9:0] trial;
  logic wrPend_r;
  logic [7:0] wrAddr_r;
  logic [31:0] rdata_r;
  logic [31:0] rdMux;
  logic shOut_r;
  logic preOut_r;

  // bus phase decode
  wire addrPhase = hsel & hready & htrans[1];
  wire cmdWr = wrPend_r && wrAddr_r == OFS_CMD;
  wire cmdStart = cmdWr & hwdata[CMD_START];
  wire cmdStop = cmdWr & hwdata[CMD_STOP];
  wire cmdRestart = cmdWr & hwdata[CMD_RESTART];
  wire cmdForce = cmdWr & hwdata[CMD_FORCE];
  wire busy = state_r != ST_IDLE;

  logic hwTrig;
  always_comb begin
    case (ctrl_r[CTL_TRG+:3])
      TRG_IN2: hwTrig = evIn2;
      TRG_IN3: hwTrig = evIn3;
      TRG_OUT3: hwTrig = evOut3;
      TRG_TIN: hwTrig = timerInputSelectTrigger;
      default: hwTrig = 1'b0;
    endcase
  end

  wire trig = !busy & (cmdStart | hwTrig);
  wire doRestart = cmdRestart & busy;
  // force only into a running scan
  wire doForce = cmdForce & busy & scan_r & !forced_r;
  wire abort = cmdStop | doRestart | doForce;
  wire finish = state_r == ST_CONV && cnt_r == CNT_W'(1) && !abort;
  // compare never runs as a scan
  wire startScan = ctrl_r[CTL_SCAN] & !ctrl_r[CTL_CMP];

  // speed selection picks the cycle count
  function automatic logic [CNT_W-1:0] convLen(input logic cmp,
      input logic fsh, input logic fast, input logic dbl);
    int n;
    n = CYC_SN;
    if (cmp) begin
      n = fast ? (dbl ? CYC_CMP_FD : CYC_CMP_FN) : (dbl ? CYC_CMP_SD : CYC_CMP_SN);
    end else if (fsh) begin
      n = fast ? (dbl ? CYC_FSH_FD : CYC_FSH_FN) : (dbl ? CYC_FSH_SD : CYC_FSH_SN);
    end else begin
      n = fast ? (dbl ? CYC_FD : CYC_FN) : (dbl ? CYC_SD : CYC_SN);
    end
    return CNT_W'(n);
  endfunction : convLen

  wire [CNT_W-1:0] curLen = convLen(curCmp_r, ctrl_r[CTL_SH] & ctrl_r[CTL_FSH],
    ctrl_r[CTL_FAST], ctrl_r[CTL_DBL]);

  // sequencer: stop beats restart beats force beats finish
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      chan_r <= 4'h0;
      savedCh_r <= 4'h0;
      scan_r <= 1'b0;
      forced_r <= 1'b0;
      pend_r <= 1'b0;
      curCmp_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (cmdStop) begin
        state_r <= ST_IDLE;
        scan_r <= 1'b0;
        forced_r <= 1'b0;
        pend_r <= 1'b0;
      end else if (doRestart) begin
        state_r <= ST_LOAD;
        forced_r <= 1'b0;
        curCmp_r <= !scan_r & ctrl_r[CTL_CMP];
        chan_r <= scan_r ? 4'h0 : singleCh_r;
      end else if (doForce) begin
        state_r <= ST_LOAD;
        forced_r <= 1'b1;
        savedCh_r <= chan_r;
        chan_r <= singleCh_r;
        curCmp_r <= 1'b1;
      end else if (trig) begin
        state_r <= ST_LOAD;
        scan_r <= startScan;
        curCmp_r <= ctrl_r[CTL_CMP];
        chan_r <= startScan ? 4'h0 : singleCh_r;
        pend_r <= ctrl_r[CTL_SAS] & !startScan & !ctrl_r[CTL_CMP];
      end else begin
        case (state_r)
          ST_LOAD: begin
            if (scan_r && !forced_r && ctrl_r[CTL_ASSIST]) begin
              state_r <= ST_PRE;
              cnt_r <= CNT_W'(PRECHG_CYC);
            end else begin
              state_r <= ST_CONV;
              cnt_r <= curLen;
            end
          end
          ST_PRE: begin
            if (cnt_r == CNT_W'(1)) begin
              state_r <= ST_CONV;
              cnt_r <= curLen;
            end else begin
              cnt_r <= cnt_r - CNT_W'(1);
            end
          end
          ST_CONV: begin
            if (!finish) begin
              cnt_r <= cnt_r - CNT_W'(1);
            end else if (forced_r) begin
              done_r <= 1'b1;
              forced_r <= 1'b0;
              chan_r <= savedCh_r;
              curCmp_r <= 1'b0;
              state_r <= ST_LOAD;
            end else if (scan_r) begin
              if (chan_r == scanLast_r) begin
                done_r <= 1'b1;
                chan_r <= 4'h0;
                if (ctrl_r[CTL_CONT]) begin
                  state_r <= ST_LOAD;
                end else begin
                  state_r <= ST_IDLE;
                  scan_r <= 1'b0;
                end
              end else begin
                chan_r <= chan_r + 4'h1;
                state_r <= ST_LOAD;
              end
            end else begin
              done_r <= 1'b1;
              if (pend_r) begin
                pend_r <= 1'b0;
                scan_r <= 1'b1;
                chan_r <= 4'h0;
                curCmp_r <= 1'b0;
                state_r <= ST_LOAD;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // bit under trial and its decision from the comparator
  wire [3:0] decIdx = cnt_r[3:0] - 4'h1;
  wire [3:0] trialIdx = cnt_r[3:0] - 4'h2;
  always_comb begin
    sarNxt = sar_r;
    trial = 10'h000;
    if (state_r == ST_CONV && cnt_r >= CNT_W'(1) && cnt_r <= CNT_W'(RES_BITS)) begin
      sarNxt[decIdx] = cmpHigh;
    end
    if (state_r == ST_CONV && cnt_r >= CNT_W'(2) && cnt_r <= CNT_W'(RES_BITS + 1)) begin
      trial[trialIdx] = 1'b1;
    end
  end

  // successive approximation over the last ten cycles
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sar_r <= 10'h000;
      dac_r <= 10'h000;
    end else if (state_r == ST_LOAD) begin
      sar_r <= 10'h000;
      dac_r <= curCmp_r ? cmpVal_r : 10'h000;
    end else if (state_r == ST_CONV && !curCmp_r) begin
      sar_r <= sarNxt;
      dac_r <= sarNxt | trial;
    end else if (state_r == ST_CONV) begin
      // compare holds the preset value on the dac
      dac_r <= cmpVal_r;
    end
  end

  // front end controls; they trail the state by one cycle
  always_ff @(posedge clock) begin
    if (!rstn) begin
      shOut_r <= 1'b0;
      preOut_r <= 1'b0;
    end else begin
      // hold switch closed only while sampling
      shOut_r <= ctrl_r[CTL_SH] && state_r == ST_CONV && cnt_r > CNT_W'(RES_BITS + 1);
      preOut_r <= state_r == ST_PRE;
    end
  end

  // per channel result and compare flag
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    wire hit = finish && chan_r == 4'(i);
    always_ff @(posedge clock) begin
      if (!rstn) begin
        data_r[i] <= 10'h000;
        cmpRes_r[i] <= 1'b0;
      end else if (hit && curCmp_r) begin
        // outcome sets or clears the flag
        cmpRes_r[i] <= cmpHigh;
      end else if (hit) begin
        data_r[i] <= sarNxt;
      end
    end
  end

  // software registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RST;
      singleCh_r <= 4'h0;
      cmpVal_r <= 10'h000;
      scanLast_r <= 4'h0;
    end else if (wrPend_r) begin
      if (wrAddr_r == OFS_CTRL) begin
        ctrl_r <= hwdata[CTL_W-1:0];
      end
      if (wrAddr_r == OFS_SINGLE) begin
        singleCh_r <= hwdata[SGL_CH+:4];
        cmpVal_r <= hwdata[SGL_CMPV+:10];
      end
      // last channel of the scan loop
      if (wrAddr_r == OFS_SCAN) begin
        scanLast_r <= 4'(hwdata[3:0] > 32'(NUM_CH - 1) ? NUM_CH - 1 : hwdata[3:0]);
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdMux = 32'h0000_0000;
    case (haddr[7:0])
      OFS_CTRL: rdMux[CTL_W-1:0] = ctrl_r;
      OFS_SINGLE: rdMux = {6'h00, cmpVal_r, 12'h000, singleCh_r};
      OFS_SCAN: rdMux[3:0] = scanLast_r;
      OFS_STATUS: rdMux = {22'h000000, state_r, forced_r, scan_r, busy,
        pend_r, chan_r};
      OFS_CMPRES: rdMux[NUM_CH-1:0] = cmpRes_r;
      default: begin
        // same result at both precisions
        // one bit wider so that a full sixteen channels still compares
        if ({1'b0, haddr[5:2]} < 5'(NUM_CH) && haddr[7:6] == REG_DATA10) begin
          rdMux[9:0] = data_r[haddr[5:2]];
        end else if ({1'b0, haddr[5:2]} < 5'(NUM_CH) && haddr[7:6] == REG_DATA8) begin
          rdMux[7:0] = data_r[haddr[5:2]][9:2];
        end
      end
    endcase
  end

  // ahb-lite slave: zero wait states, read data sampled in address phase
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      rdata_r <= 32'h0000_0000;
    end else begin
      wrPend_r <= addrPhase & hwrite;
      if (addrPhase) begin
        wrAddr_r <= haddr[7:0];
      end
      if (addrPhase && !hwrite) begin
        rdata_r <= rdMux;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;
  assign analogInputChannelSel = chan_r;
  assign dacCode = dac_r;
  assign sampleHold = shOut_r;
  assign precharge = preOut_r;
  assign prechargeHigh = ctrl_r[CTL_ALVL];
  assign convDoneReq = done_r;
endmodule : sar_adc_sequencer

// ==== analog_front_model.sv ====
// analog front end model: one input level per channel, ideal comparator
// assumes the bench sets the levels; the sequencer drives mux and dac
`timescale 1ns/1ps
module analog_front_model (
  // mux and trial code
  input wire logic [3:0] chSel,
  input wire logic [9:0] dacCode,
  // levels, channel k in bits 10k+9:10k
  input wire logic [159:0] levels,
  // comparator
  output logic cmpHigh
);
  // ideal comparator
  // equal counts as above, so a kept trial bit reproduces the level
  assign cmpHigh = levels[chSel*10 +: 10] >= dacCode;
endmodule : analog_front_model

// ==== sar_adc_sequencer_chk.sv ====
// port checker of the converter sequencer
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
module sar_adc_sequencer_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  // front end
  input wire logic [3:0] analogInputChannelSel,
  input wire logic sampleHold,
  input wire logic precharge,
  input wire logic convDoneReq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // read address phase taken
  wire rdTaken = hsel && hready && htrans[1] && !hwrite;
  sequence preRun;
    precharge [*4];
  endsequence
  sequence quietGap;
    !convDoneReq [*8];
  endsequence
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout dropped");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !convDoneReq && !precharge)
    else $error("outputs active after reset");
  a_done_single: assert property (convDoneReq |=> !convDoneReq)
    else $error("done request longer than one cycle");
  a_done_gap: assert property ($fell(convDoneReq) |-> quietGap)
    else $error("done requests too close");
  a_prechg_len: assert property ($rose(precharge) |-> preRun ##1 !precharge)
    else $error("precharge not four cycles");
  a_prechg_chan: assert property (precharge [*2] |-> $stable(analogInputChannelSel))
    else $error("channel moved during precharge");
  a_rdata_stands: assert property (!rdTaken |=> $stable(hrdata))
    else $error("read data changed without read");
endmodule : sar_adc_sequencer_chk

bind sar_adc_sequencer sar_adc_sequencer_chk chk (.clock, .rstn, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hrdata, .hresp, .analogInputChannelSel, .sampleHold, .precharge,
  .convDoneReq);

// ==== test_sar_adc_sequencer.sv ====
// self-checking bench of the converter sequencer with a reference model
// assumes analog_front_model and the bound checker are compiled first
`timescale 1ns/1ps
module test_sar_adc_sequencer;
  import sar_adc_pkg::*;
  logic clock = 0, rstn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd, hrdata;
  logic [1:0] htrans = 0;
  logic [3:0] evs = 0, chSel;
  logic hreadyout, hresp, cmpHigh, sampleHold, precharge, prechargeHigh, convDoneReq;
  logic [9:0] dacCode;
  logic [159:0] levels = 0;
  int err_total = 0, num_checks = 0, cyc = 0, tDone, t0, shSeen, preSeen, gotDone;
  int exp10[16];
  int unsigned seed = 37038;
  sar_adc_sequencer dut (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .evIn2(evs[0]), .evIn3(evs[1]),
    .evOut3(evs[2]), .timerInputSelectTrigger(evs[3]), .cmpHigh(cmpHigh),
    .analogInputChannelSel(chSel), .dacCode(dacCode), .sampleHold(sampleHold),
    .precharge(precharge), .prechargeHigh(prechargeHigh), .convDoneReq(convDoneReq));
  analog_front_model afe (.chSel(chSel), .dacCode(dacCode), .levels(levels),
    .cmpHigh(cmpHigh));
  // clock, cycle count and phase monitors
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (sampleHold === 1'b1) shSeen = 1;
    if (precharge === 1'b1) preSeen = 1;
  end
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // expected length including load edge and registered pulse
  function automatic int ncyc(logic [31:0] c);
    int t[12] = '{CYC_SN, CYC_SD, CYC_FN, CYC_FD, CYC_FSH_SN, CYC_FSH_SD, CYC_FSH_FN,
      CYC_FSH_FD, CYC_CMP_SN, CYC_CMP_SD, CYC_CMP_FN, CYC_CMP_FD};
    int b = c[CTL_CMP] ? 8 : (c[CTL_SH] && c[CTL_FSH]) ? 4 : 0;
    return t[b + 2 * c[CTL_FAST] + c[CTL_DBL]] + 2;
  endfunction : ncyc
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", nm, ex, got);
    end
  endtask : chk
  // one ahb-lite single transfer, entered just after a rising edge
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    int n = 0;
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin err_total++; tally_and_finish(); end
  endtask : bus
  task automatic wait_done(int lim, bit must);
    int n = 0;
    do begin @(posedge clock); n++; end while (convDoneReq !== 1'b1 && n < lim);
    tDone = cyc;
    gotDone = (convDoneReq === 1'b1);
    if (must && !gotDone) begin err_total++; tally_and_finish(); end
  endtask : wait_done
  task automatic data_chk(int ch);
    bus(0, {REG_DATA10, ch[3:0], 2'h0}, 0);
    chk("data10", exp10[ch], rd);
    bus(0, {REG_DATA8, ch[3:0], 2'h0}, 0);
    chk("data8", exp10[ch] >> 2, rd);
  endtask : data_chk
  task automatic single(logic [31:0] ctl, int ch, int v, int cv);
    levels[ch*10 +: 10] <= v[9:0];
    bus(1, OFS_CTRL, ctl);
    bus(1, OFS_SINGLE, ch | (cv << SGL_CMPV));
    shSeen = 0;
    bus(1, OFS_CMD, 32'h1);
    t0 = cyc;
    wait_done(400, 1);
    chk("cycles", ncyc(ctl), tDone - t0);
    chk("hold", ctl[CTL_SH], shSeen);
    if (ctl[CTL_CMP]) begin
      bus(0, OFS_CMPRES, 0);
      chk("cmpbit", v >= cv, rd[ch]);
    end else begin
      exp10[ch] = v;
      data_chk(ch);
    end
  endtask : single
  task automatic scan(logic [31:0] ctl, int last, int nDone);
    for (int k = 0; k < 16; k++) begin
      exp10[k] = rnd() % 1024;
      levels[k*10 +: 10] <= exp10[k][9:0];
    end
    bus(1, OFS_SCAN, last);
    bus(1, OFS_SINGLE, 9);
    // the queued scan needs the scan bit clear
    bus(1, OFS_CTRL, ctl | (ctl[CTL_SAS] ? 32'h60 : 32'h61));
    // level register lands at the data phase edge
    @(posedge clock);
    chk("plevel", ctl[CTL_ALVL], prechargeHigh);
    preSeen = 0;
    bus(1, OFS_CMD, 32'h1);
    for (int k = 0; k < nDone; k++) wait_done(20000, 1);
    // stop past the precharge so it is not cut short
    if (ctl[CTL_CONT]) begin
      repeat (8) @(posedge clock);
      bus(1, OFS_CMD, 32'h2);
    end
    wait_done(1500, 0);
    chk("stopped", 0, gotDone);
    chk("prechg", ctl[CTL_ASSIST], preSeen);
    for (int k = 0; k <= last; k++) data_chk(k);
    if (ctl[CTL_SAS]) data_chk(9);
  endtask : scan
  initial begin
    repeat (4) @(posedge clock);
    rstn <= 1;
    @(posedge clock);
    bus(0, OFS_CTRL, 0);
    chk("ctrl", CTRL_RST, rd);
    bus(0, 8'h30, 0);
    chk("unmapped", 0, rd);
    // every speed with hold off, hold on and fast hold
    for (int i = 0; i < 12; i++)
      single(((i % 4) << CTL_FAST) | ((i / 4 > 0) << CTL_SH) | ((i / 4 == 2) << CTL_FSH),
        rnd() % 16, rnd() % 1024, 0);
    // compare with the scan bit set stays single
    for (int i = 0; i < 8; i++)
      single(((i % 4) << CTL_FAST) | 32'h5, rnd() % 16, rnd() % 1024, rnd() % 1024);
    scan(0, 3, 1);
    scan((1 << CTL_ASSIST) | (1 << CTL_ALVL) | 2, 2, 2);
    scan(1 << CTL_SAS, 1, 2);
    levels[129:120] <= 10'h155;
    bus(1, OFS_CTRL, 32'h63);
    bus(1, OFS_CMD, 32'h1);
    wait_done(20000, 1);
    // equal level reads as above, one count more as below
    for (int k = 0; k < 2; k++) begin
      bus(1, OFS_SINGLE, 12 | ((32'h155 + k) << SGL_CMPV));
      bus(1, OFS_CMD, 32'h8);
      wait_done(200, 1);
      bus(0, OFS_CMPRES, 0);
      chk("forced", k == 0, rd[12]);
    end
    bus(1, OFS_CMD, 32'h2);
    // each timer source, foreign one ignored
    for (int k = 0; k < 4; k++) begin
      bus(1, OFS_CTRL, ((k + 1) << CTL_TRG) | 32'h60);
      evs[(k + 1) % 4] <= 1;
      @(posedge clock);
      evs[(k + 1) % 4] <= 0;
      wait_done(300, 0);
      chk("foreign", 0, gotDone);
      evs[k] <= 1;
      @(posedge clock);
      evs[k] <= 0;
      t0 = cyc;
      wait_done(300, 1);
      chk("hwcycles", CYC_FD + 2, tDone - t0);
    end
    // start while busy ignored, then restart
    bus(1, OFS_CTRL, 0);
    bus(1, OFS_SINGLE, 2);
    bus(1, OFS_CMD, 32'h1);
    t0 = cyc;
    repeat (30) @(posedge clock);
    bus(1, OFS_CMD, 32'h1);
    wait_done(400, 1);
    chk("busy", CYC_SN + 2, tDone - t0);
    bus(1, OFS_CMD, 32'h1);
    repeat (60) @(posedge clock);
    exp10[2] = 10'h2A5;
    levels[29:20] <= 10'h2A5;
    bus(1, OFS_CMD, 32'h4);
    t0 = cyc;
    wait_done(400, 1);
    chk("restart", CYC_SN + 2, tDone - t0);
    data_chk(2);
    tally_and_finish();
  end
  initial begin
    repeat (100000) @(posedge clock);
    err_total++;
    tally_and_finish();
  end
endmodule : test_sar_adc_sequencer
